// ===== common/mcr_pkg.sv
// Register map, field layout and carrier types of the maintenance-channel bank
package mcr_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_OPERATION_MODE = 10'h060;
  localparam logic [9:0] IDX_FILTER = 10'h061;
  localparam logic [9:0] IDX_MSG_RD = 10'h063;
  localparam logic [9:0] IDX_MSG_WR = 10'h065;
  localparam logic [9:0] IDX_RMASK = 10'h067;
  localparam logic [9:0] IDX_WMASK = 10'h068;
  localparam logic [9:0] IDX_M4_RD = 10'h069;
  localparam logic [9:0] IDX_M4_WR = 10'h06a;
  localparam logic [9:0] IDX_SPR_RD = 10'h06b;
  localparam logic [9:0] IDX_SPR_WR = 10'h06c;
  localparam logic [9:0] IDX_CODE_RD = 10'h06d;
  localparam logic [9:0] IDX_CODE_WR = 10'h06e;
  // Reset values
  localparam logic [7:0] RST_OPERATION_MODE = 8'h14;
  localparam logic [7:0] RST_FILTER = 8'h14;
  localparam logic [15:0] RST_MSG_RD = 16'h0fff;
  localparam logic [15:0] RST_MSG_WR = 16'h0100;
  localparam logic [7:0] RST_RMASK = 8'h00;
  localparam logic [7:0] RST_WMASK = 8'ha8;
  localparam logic [7:0] RST_M4 = 8'hbe;
  localparam logic [7:0] RST_SPR_WR = 8'hff;
  localparam logic [3:0] RST_CODE_WR = 4'h0;
  // Operation mode fields and writable bits
  localparam int OPM_UCI = 6;
  localparam int OPM_FAR_END_BLOCK_ERROR = 5;
  localparam int OPM_MLT = 4;
  localparam int OPM_CISEL = 2;
  localparam logic [7:0] OPM_WMSK = 8'h74;
  // Filter fields
  localparam int FLT_EOC_LSB = 0;
  localparam int FLT_M4_LSB = 3;
  localparam int FLT_M4_SM = 5;
  localparam int FLT_SPR = 6;
  // Spare-bit read layout
  localparam int SPR_FAR_END_BLOCK_ERROR = 0;
  localparam int SPR_BITS_LSB = 1;
  localparam int SPR_NEBE = 4;
  localparam int SPR_LOOP_LSB = 5;
  // Message layout
  localparam logic [15:0] MSG_WMSK = 16'h0fff;
  localparam int MSG_DM = 8;
  localparam logic [3:0] CODE_IDLE = 4'hf;
  // Operations-channel handling modes
  typedef enum logic [2:0] {
    EOC_TRANSP = 3'b001,
    EOC_ONCHG = 3'b010,
    EOC_TLL = 3'b011,
    EOC_AUTO = 3'b100
  } mcr_eoc_mode_t;
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mcr_apb_req_t;
  // Line-side inputs; codes taken every enabled cycle, status bits at reads, the rest at superframe strobes
  typedef struct packed {
    logic sf_strobe;
    logic line_active;
    logic crc_ok;
    logic [7:0] m4;
    logic [2:0] spare;
    logic [11:0] msg;
    logic [3:0] sm_code;
    logic [3:0] bus_code;
    logic [7:0] sm_m4;
    logic far_end_block_error_count;
    logic nebe;
    logic far_end_block_error_rx;
    logic [1:0] loop_state;
  } mcr_rx_t;
  // Line-side outputs, all from flip-flops
  typedef struct packed {
    logic [11:0] msg;
    logic msg_on;
    logic [7:0] m4;
    logic [2:0] spare;
    logic far_end_block_error;
    logic [3:0] bus_code;
    logic [3:0] sm_cmd;
    logic [7:0] sm_m4;
    logic m4_evt;
    logic diag_evt;
    logic [7:0] diag_info;
  } mcr_tx_t;
endpackage

// ===== logic/mcr_regs.sv
// Maintenance-channel register bank with APB slave and bit validation
//
// Notes on behaviour
// - Processor code control set: codes via registers, bus code slot idles at 1111.
// - Processor code control clear: codes via serial bus, code still readable.
// - Far-end block error from internal counter, or processor value when enabled.
// - Loop termination enabled only by its bit; state shown in spare read.
// - Indication set select picks standard or simplified indication codes.
// - Spare filter low bit zero copies fourth-bit validation, one means on change.
// - Fourth-bit filter low bits: on change, TRIPLE_LAST_LOOK, CRC, CRC plus TRIPLE_LAST_LOOK.
// - Filter top bit: state machine bits use TRIPLE_LAST_LOOK, or the reporting validation.
// - Operations field: 100 automatic, 001 raw, 010 on change, 011 TRIPLE_LAST_LOOK.
// - Message read register holds latest message passing the chosen filter.
// - Message registers: zero nibble, address, data/message flag, information byte.
// - Written message sent next superframe and repeated until rewrite or deactivation.
// - Eight reserved information codes are diagnostic, not free data.
// - Read mask bit zero lets a fourth-bit change raise the event.
// - Write mask bit one takes transmitted fourth bit from processor value.
// - Loop status 00 normal, 01 insertion loss, 10 quiet, at bits 6:5.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module mcr_regs #(
  parameter logic [63:0] DIAG_CODES = 64'h0807060504030201 // Arbitrary codes
) (
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire mcr_pkg::mcr_apb_req_t APB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire mcr_pkg::mcr_rx_t RX_I,
  output mcr_pkg::mcr_tx_t TX_O,
  output logic LOOP_TERM_EN_O,
  output logic IND_SET_O
);

  typedef struct packed {
    logic [7:0] opm;
    logic [7:0] flt;
    logic [15:0] msg_rd;
    logic [15:0] msg_wr;
    logic [7:0] rmask;
    logic [7:0] wmask;
    logic [7:0] m4_rd;
    logic [7:0] m4_wr;
    logic [7:0] spr_wr;
    logic [3:0] code_wr;
    logic [3:0] code_rd;
    logic [7:0] m4_h1;
    logic [7:0] m4_h2;
    logic [2:0] sp_h1;
    logic [2:0] sp_h2;
    logic [2:0] sp_val;
    logic [11:0] msg_h1;
    logic [11:0] msg_h2;
    logic [31:0] prdata;
    logic ack;
    logic slverr;
    mcr_pkg::mcr_tx_t tx;
  } mcr_state_t;

  mcr_state_t st_r;
  mcr_state_t st_nxt;
  logic [9:0] idx;
  logic setup;
  logic done;
  logic proc_code_control;
  logic [2:0] eoc_md;
  logic [7:0] m4_keep;
  logic [7:0] m4_val;
  logic [7:0] sm_keep;
  logic [7:0] sp_keep;
  logic [1:0] sp_md;
  logic msg_ok;
  logic is_diag;

  // Bits allowed to load a new value under a validation mode
  function automatic logic [7:0] mcr_keep(input logic [1:0] md,
                                          input logic [7:0] nw,
                                          input logic [7:0] h1,
                                          input logic [7:0] h2,
                                          input logic crc);
    logic [7:0] triple_last_look;
    triple_last_look = ~(nw ^ h1) & ~(h1 ^ h2);
    unique case (md)
      2'b00: mcr_keep = 8'hff;
      2'b01: mcr_keep = triple_last_look;
      2'b10: mcr_keep = {8{crc}};
      2'b11: mcr_keep = triple_last_look & {8{crc}};
    endcase
  endfunction

  // Read multiplexer
  function automatic logic [32:0] mcr_read(input mcr_state_t s,
                                           input mcr_pkg::mcr_rx_t rx,
                                           input logic [9:0] a);
    logic [7:0] spr;
    spr = 8'h00;
    spr[mcr_pkg::SPR_FAR_END_BLOCK_ERROR] = rx.far_end_block_error_rx;
    spr[mcr_pkg::SPR_BITS_LSB +: 3] = s.sp_val;
    spr[mcr_pkg::SPR_NEBE] = rx.nebe;
    spr[mcr_pkg::SPR_LOOP_LSB +: 2] = rx.loop_state;
    mcr_read = {1'b0, 32'h0000_0000};
    unique case (a)
      mcr_pkg::IDX_OPERATION_MODE: mcr_read[7:0] = s.opm;
      mcr_pkg::IDX_FILTER: mcr_read[7:0] = s.flt;
      mcr_pkg::IDX_MSG_RD: mcr_read[15:0] = s.msg_rd;
      mcr_pkg::IDX_MSG_WR: mcr_read[15:0] = 16'h0000;
      mcr_pkg::IDX_RMASK: mcr_read[7:0] = s.rmask;
      mcr_pkg::IDX_WMASK: mcr_read[7:0] = s.wmask;
      mcr_pkg::IDX_M4_RD: mcr_read[7:0] = s.m4_rd;
      mcr_pkg::IDX_M4_WR: mcr_read[7:0] = 8'h00;
      mcr_pkg::IDX_SPR_RD: mcr_read[7:0] = spr;
      mcr_pkg::IDX_SPR_WR: mcr_read[7:0] = 8'h00;
      mcr_pkg::IDX_CODE_RD: mcr_read[3:0] = s.code_rd;
      mcr_pkg::IDX_CODE_WR: mcr_read[7:0] = 8'h00;
      default: mcr_read[32] = 1'b1; // Unmapped: error
    endcase
  endfunction

  // Bus decode helpers
  assign idx = APB_I.paddr[11:2];
  assign setup = APB_I.psel && !APB_I.penable && !st_r.ack;
  assign done = APB_I.psel && APB_I.penable && st_r.ack;
  assign proc_code_control = st_r.opm[mcr_pkg::OPM_UCI];
  assign eoc_md = st_r.flt[mcr_pkg::FLT_EOC_LSB +: 3];

  // Validation masks for the current superframe
  always_comb begin
    m4_keep = mcr_keep(st_r.flt[mcr_pkg::FLT_M4_LSB +: 2], RX_I.m4,
                       st_r.m4_h1, st_r.m4_h2, RX_I.crc_ok);
    m4_val = (m4_keep & RX_I.m4) | (~m4_keep & st_r.m4_rd);
    sm_keep = mcr_keep(2'b01, RX_I.m4, st_r.m4_h1, st_r.m4_h2,
                       RX_I.crc_ok);
    sp_md = st_r.flt[mcr_pkg::FLT_SPR] ? 2'b00
          : st_r.flt[mcr_pkg::FLT_M4_LSB +: 2];
    sp_keep = mcr_keep(sp_md, {5'h00, RX_I.spare}, {5'h00, st_r.sp_h1},
                       {5'h00, st_r.sp_h2}, RX_I.crc_ok);
  end

  // Operations message acceptance
  always_comb begin
    unique case (eoc_md)
      mcr_pkg::EOC_TRANSP: msg_ok = 1'b1;
      mcr_pkg::EOC_ONCHG: msg_ok = RX_I.msg != st_r.msg_rd[11:0];
      mcr_pkg::EOC_TLL,
      mcr_pkg::EOC_AUTO: msg_ok = (RX_I.msg == st_r.msg_h1)
                                 && (st_r.msg_h1 == st_r.msg_h2);
      default: msg_ok = 1'b0;
    endcase
    is_diag = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (RX_I.msg[7:0] == DIAG_CODES[8*i +: 8]) begin
        is_diag = 1'b1;
      end
    end
  end

  // Next-state logic
  always_comb begin
    logic [32:0] rd;
    rd = mcr_read(st_r, RX_I, idx);
    st_nxt = st_r;
    if (CE_I) begin
      // Event pulses last one enabled cycle; a frozen block keeps them
      st_nxt.tx.m4_evt = 1'b0;
      st_nxt.tx.diag_evt = 1'b0;
      // Code exchange path
      st_nxt.code_rd = RX_I.sm_code;
      st_nxt.tx.bus_code = proc_code_control ? mcr_pkg::CODE_IDLE : RX_I.sm_code;
      st_nxt.tx.sm_cmd = proc_code_control ? st_r.code_wr : RX_I.bus_code;
      // APB setup: capture read data and error
      if (setup) begin
        st_nxt.ack = 1'b1;
        st_nxt.prdata = rd[31:0];
        st_nxt.slverr = rd[32];
      end
      // APB access end: write takes effect
      if (done) begin
        st_nxt.ack = 1'b0;
        if (APB_I.pwrite && !st_r.slverr) begin
          unique case (idx)
            mcr_pkg::IDX_OPERATION_MODE:
              st_nxt.opm = APB_I.pwdata[7:0] & mcr_pkg::OPM_WMSK;
            mcr_pkg::IDX_FILTER: st_nxt.flt = APB_I.pwdata[7:0];
            mcr_pkg::IDX_MSG_WR:
              st_nxt.msg_wr = APB_I.pwdata[15:0] & mcr_pkg::MSG_WMSK;
            mcr_pkg::IDX_RMASK: st_nxt.rmask = APB_I.pwdata[7:0];
            mcr_pkg::IDX_WMASK: st_nxt.wmask = APB_I.pwdata[7:0];
            mcr_pkg::IDX_M4_WR: st_nxt.m4_wr = APB_I.pwdata[7:0];
            mcr_pkg::IDX_SPR_WR: st_nxt.spr_wr = APB_I.pwdata[7:0];
            mcr_pkg::IDX_CODE_WR: st_nxt.code_wr = APB_I.pwdata[3:0];
            default: st_nxt.opm = st_r.opm;
          endcase
        end
      end
      // Superframe processing: settings apply from here on
      if (RX_I.sf_strobe) begin
        st_nxt.tx.msg = st_r.msg_wr[11:0];
        st_nxt.tx.msg_on = RX_I.line_active;
        st_nxt.tx.m4 = (st_r.wmask & st_r.m4_wr)
                     | (~st_r.wmask & RX_I.sm_m4);
        st_nxt.tx.spare = st_r.spr_wr[mcr_pkg::SPR_BITS_LSB +: 3];
        st_nxt.tx.far_end_block_error = st_r.opm[mcr_pkg::OPM_FAR_END_BLOCK_ERROR]
                       ? st_r.spr_wr[mcr_pkg::SPR_FAR_END_BLOCK_ERROR] : RX_I.far_end_block_error_count;
        // Fourth maintenance bits
        st_nxt.m4_rd = m4_val;
        st_nxt.tx.m4_evt = |((m4_val ^ st_r.m4_rd) & ~st_r.rmask);
        st_nxt.tx.sm_m4 = st_r.flt[mcr_pkg::FLT_M4_SM] ? m4_val
                        : (sm_keep & RX_I.m4) | (~sm_keep & st_r.tx.sm_m4);
        st_nxt.m4_h2 = st_r.m4_h1;
        st_nxt.m4_h1 = RX_I.m4;
        // Spare bits
        st_nxt.sp_val = (sp_keep[2:0] & RX_I.spare)
                      | (~sp_keep[2:0] & st_r.sp_val);
        st_nxt.sp_h2 = st_r.sp_h1;
        st_nxt.sp_h1 = RX_I.spare;
        // Operations messages
        st_nxt.msg_h2 = st_r.msg_h1;
        st_nxt.msg_h1 = RX_I.msg;
        if (msg_ok) begin
          st_nxt.msg_rd = {4'h0, RX_I.msg};
          if (eoc_md == mcr_pkg::EOC_AUTO && RX_I.msg[mcr_pkg::MSG_DM] && is_diag) begin
            st_nxt.tx.diag_evt = 1'b1;
            st_nxt.tx.diag_info = RX_I.msg[7:0];
          end
        end
      end
    end
  end

  // State register with reset to documented values
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r <= '0;
      st_r.opm <= mcr_pkg::RST_OPERATION_MODE;
      st_r.flt <= mcr_pkg::RST_FILTER;
      st_r.msg_rd <= mcr_pkg::RST_MSG_RD;
      st_r.msg_wr <= mcr_pkg::RST_MSG_WR;
      st_r.rmask <= mcr_pkg::RST_RMASK;
      st_r.wmask <= mcr_pkg::RST_WMASK;
      st_r.m4_rd <= mcr_pkg::RST_M4;
      st_r.m4_wr <= mcr_pkg::RST_M4;
      st_r.spr_wr <= mcr_pkg::RST_SPR_WR;
      st_r.code_wr <= mcr_pkg::RST_CODE_WR;
      st_r.sp_val <= mcr_pkg::RST_SPR_WR[3:1];
      st_r.tx.sm_m4 <= mcr_pkg::RST_M4;
      st_r.tx.m4 <= mcr_pkg::RST_M4;
      st_r.tx.bus_code <= mcr_pkg::CODE_IDLE;
      st_r.msg_h1 <= mcr_pkg::RST_MSG_RD[11:0];
      st_r.msg_h2 <= mcr_pkg::RST_MSG_RD[11:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign PRDATA_O = st_r.prdata;
  assign PREADY_O = st_r.ack && CE_I;
  assign PSLVERR_O = st_r.ack && CE_I && st_r.slverr;
  assign TX_O = st_r.tx;
  assign LOOP_TERM_EN_O = st_r.opm[mcr_pkg::OPM_MLT];
  assign IND_SET_O = st_r.opm[mcr_pkg::OPM_CISEL];

  // Checks
  a_idle_code_slot:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && proc_code_control |=> TX_O.bus_code == mcr_pkg::CODE_IDLE)
  else $error("code slot not idle under processor control");

  // The edge that leaves reset still loads reset values, hence the guard
  a_bus_code_pass:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    $past(ARST_N_I) && CE_I && !proc_code_control |=> TX_O.bus_code == $past(RX_I.sm_code)
                     && TX_O.sm_cmd == $past(RX_I.bus_code))
  else $error("codes not passed over serial bus");

  a_far_end_block_error_source:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe |=> TX_O.far_end_block_error == ($past(st_r.opm[mcr_pkg::OPM_FAR_END_BLOCK_ERROR])
      ? $past(st_r.spr_wr[mcr_pkg::SPR_FAR_END_BLOCK_ERROR]) : $past(RX_I.far_end_block_error_count)))
  else $error("block error bit from wrong source");

  a_loop_enable_write:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && done && APB_I.pwrite && idx == mcr_pkg::IDX_OPERATION_MODE
    |=> LOOP_TERM_EN_O == $past(APB_I.pwdata[mcr_pkg::OPM_MLT])
        && IND_SET_O == $past(APB_I.pwdata[mcr_pkg::OPM_CISEL]))
  else $error("mode write not applied");

  a_loop_status_read:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && setup && idx == mcr_pkg::IDX_SPR_RD
    |=> PRDATA_O[6:5] == $past(RX_I.loop_state) && PRDATA_O[7] == 1'b0)
  else $error("loop status misplaced");

  a_msg_repeat:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe |=> TX_O.msg == $past(st_r.msg_wr[11:0])
                               && TX_O.msg_on == $past(RX_I.line_active))
  else $error("message not sent each superframe");

  a_tx_fourth_mask:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe
    |=> TX_O.m4 == (($past(st_r.wmask) & $past(st_r.m4_wr))
                    | (~$past(st_r.wmask) & $past(RX_I.sm_m4))))
  else $error("fourth bit source wrong");

  a_fourth_event:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe && ((m4_val ^ st_r.m4_rd) & ~st_r.rmask) != 8'h00
    |=> TX_O.m4_evt ##1 (!TX_O.m4_evt || $past(RX_I.sf_strobe) || !$past(CE_I)))
  else $error("unmasked change gave no single event");

  a_transp_accept:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe && eoc_md == mcr_pkg::EOC_TRANSP
    |=> st_r.msg_rd == {4'h0, $past(RX_I.msg)})
  else $error("transparent message not taken");

  a_apb_ready:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && setup ##1 CE_I && APB_I.psel && APB_I.penable |-> PREADY_O)
  else $error("no zero-wait answer");

  a_ready_single:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    PREADY_O |=> !PREADY_O)
  else $error("ready held past one access cycle");

  a_mode_write_mask:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && done && APB_I.pwrite && idx == mcr_pkg::IDX_OPERATION_MODE
    |=> st_r.opm == ($past(APB_I.pwdata[7:0]) & mcr_pkg::OPM_WMSK))
  else $error("mode register write lost");

  a_msg_write_mask:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && done && APB_I.pwrite && idx == mcr_pkg::IDX_MSG_WR
    |=> st_r.msg_wr == {4'h0, $past(APB_I.pwdata[11:0])})
  else $error("message write layout wrong");

  a_mask_readback:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && done && APB_I.pwrite && idx == mcr_pkg::IDX_WMASK
    |=> st_r.wmask == $past(APB_I.pwdata[7:0]))
  else $error("write mask not stored");

  a_code_read_live:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && $past(CE_I) && setup && idx == mcr_pkg::IDX_CODE_RD
    |=> PRDATA_O[3:0] == $past(RX_I.sm_code, 2))
  else $error("code read not the state machine code");

  a_spare_on_change:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe && st_r.flt[mcr_pkg::FLT_SPR]
    |=> st_r.sp_val == $past(RX_I.spare))
  else $error("spare bits not taken on change");

  a_sm_bits_tll:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe && !st_r.flt[mcr_pkg::FLT_M4_SM]
      && RX_I.m4 == st_r.m4_h1 && st_r.m4_h1 == st_r.m4_h2
    |=> TX_O.sm_m4 == $past(RX_I.m4))
  else $error("state machine bits miss three-look value");

  a_diag_auto_only:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    TX_O.diag_evt && $past(CE_I)
    |-> $past(eoc_md) == mcr_pkg::EOC_AUTO && $past(RX_I.msg[mcr_pkg::MSG_DM])
        && TX_O.diag_info == $past(RX_I.msg[7:0]))
  else $error("diagnostic event outside automatic message");

  a_m4_on_change:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe && st_r.flt[mcr_pkg::FLT_M4_LSB +: 2] == 2'b00
    |=> st_r.m4_rd == $past(RX_I.m4))
  else $error("fourth bits not taken on change");

  a_m4_crc_hold:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe && st_r.flt[mcr_pkg::FLT_M4_LSB +: 2] == 2'b10 && !RX_I.crc_ok
    |=> st_r.m4_rd == $past(st_r.m4_rd))
  else $error("fourth bits taken despite bad check");

  a_tll_msg_hold:
  assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && RX_I.sf_strobe && eoc_md == mcr_pkg::EOC_TLL && RX_I.msg != st_r.msg_h1
    |=> st_r.msg_rd == $past(st_r.msg_rd))
  else $error("unconfirmed message accepted");

endmodule

// ===== testbench/tb_mcr_regs.sv
// Self-checking bench for the maintenance-channel register bank
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_mcr_regs;
  localparam logic [63:0] DIAG = 64'h0807060504030201; // Arbitrary reserved codes
  logic clk;
  logic arst_n;
  logic ce;
  mcr_pkg::mcr_apb_req_t apb;
  mcr_pkg::mcr_rx_t rx;
  mcr_pkg::mcr_rx_t nx;
  mcr_pkg::mcr_tx_t tx;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic loop_en;
  logic ind_set;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] diag_last;
  int fail_count;
  int samples_checked;
  int m4_evts;
  int diag_evts;
  int n;
  logic [9:0] ridx [6] = '{mcr_pkg::IDX_OPERATION_MODE, mcr_pkg::IDX_FILTER, mcr_pkg::IDX_MSG_RD,
    mcr_pkg::IDX_MSG_WR, mcr_pkg::IDX_RMASK, mcr_pkg::IDX_WMASK};
  logic [31:0] rval [6] = '{32'h14, 32'h14, 32'h0fff, 32'h0, 32'h0, 32'ha8};

  mcr_regs #(.DIAG_CODES(DIAG)) u_dut (
    .CLOCK_I(clk),
    .ARST_N_I(arst_n),
    .CE_I(ce),
    .APB_I(apb),
    .PRDATA_O(prdata),
    .PREADY_O(pready),
    .PSLVERR_O(pslverr),
    .RX_I(rx),
    .TX_O(tx),
    .LOOP_TERM_EN_O(loop_en),
    .IND_SET_O(ind_set)
  );

  // Free-running clock
  always #50 clk = ~clk;

  // Pulse counters for the event outputs
  always @(posedge clk) begin
    if (tx.m4_evt === 1'b1) m4_evts++;
    if (tx.diag_evt === 1'b1) begin
      diag_evts++;
      diag_last = tx.diag_info;
    end
  end

  // One APB transfer; waits for ready and counts access cycles
  task automatic apb_xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= wr;
    apb.paddr <= {idx, 2'b00};
    apb.pwdata <= wd;
    @(posedge clk);
    apb.penable <= 1'b1;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    `CHK(k, 1)
    rdat = prdata;
    rerr = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb_xfer(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e);
    apb_xfer(1'b0, idx, 32'h0);
    `CHK(rdat, e)
  endtask

  // One superframe strobe carrying the given line inputs
  task automatic sf(input mcr_pkg::mcr_rx_t v);
    v.sf_strobe = 1'b1;
    @(posedge clk);
    rx <= v;
    @(posedge clk);
    rx.sf_strobe <= 1'b0;
    @(negedge clk);
  endtask

  task automatic end_of_test();
    $display("TB: compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #300000;
    fail_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    apb = '0;
    nx = '0;
    nx.line_active = 1'b1;
    nx.m4 = 8'hbe;
    nx.sm_code = 4'h9;
    nx.bus_code = 4'h6;
    nx.sm_m4 = 8'hc3;
    nx.far_end_block_error_count = 1'b1;
    rx = nx;
    @(negedge clk);
    `CHK({loop_en, ind_set, tx.bus_code, tx.m4}, {2'b11, 4'hf, 8'hbe})
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values over the bus
    for (int i = 0; i < 6; i++) rd_chk(ridx[i], rval[i]);
    // Codes over the serial bus while processor control is off
    @(negedge clk);
    `CHK({tx.bus_code, tx.sm_cmd}, {4'h9, 4'h6})
    rd_chk(mcr_pkg::IDX_CODE_RD, 32'h9);
    // Processor control on: bus slot idles, command from code write
    wr(mcr_pkg::IDX_OPERATION_MODE, 32'hff);
    rd_chk(mcr_pkg::IDX_OPERATION_MODE, 32'h74);
    wr(mcr_pkg::IDX_CODE_WR, 32'hc);
    repeat (2) @(negedge clk);
    `CHK({tx.bus_code, tx.sm_cmd, loop_en, ind_set}, {4'hf, 4'hc, 2'b11})
    wr(mcr_pkg::IDX_OPERATION_MODE, 32'h10);
    repeat (2) @(negedge clk);
    `CHK({tx.bus_code, tx.sm_cmd, loop_en, ind_set}, {4'h9, 4'h6, 2'b10})
    wr(mcr_pkg::IDX_OPERATION_MODE, 32'h04);
    repeat (2) @(negedge clk);
    `CHK({loop_en, ind_set}, 2'b01)
    // Far-end block error source
    wr(mcr_pkg::IDX_SPR_WR, 32'hfe);
    wr(mcr_pkg::IDX_OPERATION_MODE, 32'h20);
    sf(nx);
    `CHK({tx.far_end_block_error, tx.spare}, {1'b0, 3'b111})
    wr(mcr_pkg::IDX_OPERATION_MODE, 32'h00);
    sf(nx);
    `CHK(tx.far_end_block_error, 1'b1)
    // Fourth-bit masks, on-change validation, spare read layout
    wr(mcr_pkg::IDX_FILTER, 32'h01);
    wr(mcr_pkg::IDX_RMASK, 32'hfe);
    wr(mcr_pkg::IDX_WMASK, 32'h0f);
    wr(mcr_pkg::IDX_M4_WR, 32'h5a);
    nx.m4 = 8'hbf;
    nx.loop_state = 2'b10;
    nx.nebe = 1'b1;
    nx.spare = 3'b101;
    n = m4_evts;
    sf(nx);
    repeat (3) @(posedge clk);
    `CHK(m4_evts - n, 1)
    `CHK(tx.m4, 8'hca)
    rd_chk(mcr_pkg::IDX_M4_RD, 32'hbf);
    rd_chk(mcr_pkg::IDX_SPR_RD, 32'h5a);
    rd_chk(mcr_pkg::IDX_WMASK, 32'h0f);
    nx.m4 = 8'hbd;
    n = m4_evts;
    sf(nx);
    repeat (3) @(posedge clk);
    `CHK(m4_evts - n, 0)
    rd_chk(mcr_pkg::IDX_M4_RD, 32'hbd);
    // Spare bits on change while fourth bits need three looks
    wr(mcr_pkg::IDX_FILTER, 32'h48);
    nx.m4 = 8'h3c;
    nx.spare = 3'b010;
    sf(nx);
    rd_chk(mcr_pkg::IDX_SPR_RD, 32'h54);
    rd_chk(mcr_pkg::IDX_M4_RD, 32'hbd);
    // Message sent and repeated, transparent receive
    wr(mcr_pkg::IDX_FILTER, 32'h01);
    wr(mcr_pkg::IDX_MSG_WR, 32'h0abc);
    nx.msg = 12'h345;
    sf(nx);
    `CHK({tx.msg_on, tx.msg}, {1'b1, 12'habc})
    sf(nx);
    `CHK({tx.msg_on, tx.msg}, {1'b1, 12'habc})
    rd_chk(mcr_pkg::IDX_MSG_RD, 32'h0345);
    // Three-look message filter
    wr(mcr_pkg::IDX_FILTER, 32'h03);
    nx.msg = 12'h111;
    sf(nx);
    sf(nx);
    rd_chk(mcr_pkg::IDX_MSG_RD, 32'h0345);
    sf(nx);
    rd_chk(mcr_pkg::IDX_MSG_RD, 32'h0111);
    wr(mcr_pkg::IDX_MSG_RD, 32'h0222);
    rd_chk(mcr_pkg::IDX_MSG_RD, 32'h0111);
    apb_xfer(1'b0, 10'h070, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    // Automatic mode: reserved info code flagged, free data not
    wr(mcr_pkg::IDX_FILTER, 32'h04);
    nx.msg = {3'b010, 1'b1, DIAG[23:16]};
    n = diag_evts;
    repeat (3) sf(nx);
    repeat (3) @(posedge clk);
    `CHK(diag_evts - n, 1)
    `CHK(diag_last, DIAG[23:16])
    nx.msg = 12'h555;
    n = diag_evts;
    repeat (4) sf(nx);
    repeat (3) @(posedge clk);
    `CHK(diag_evts - n, 0)
    // Frozen block ignores a superframe
    @(posedge clk);
    ce <= 1'b0;
    nx.line_active = 1'b0;
    sf(nx);
    `CHK(tx.msg_on, 1'b1)
    // Line deactivation stops the message
    @(posedge clk);
    ce <= 1'b1;
    sf(nx);
    `CHK(tx.msg_on, 1'b0)
    // Reset in mid-run restores the registers
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(ridx[i], rval[i]);
    end_of_test();
  end
endmodule
